/* hdl/ceau_pkg.sv */
// Purpose: Shared types and constants of the effective address unit
// Assumes: 16-bit instruction words, 24-bit address space
// Notes:   Field positions refer to the first instruction word
package ceau_pkg;

	typedef enum logic [3:0] {
		MODE_REG_DIRECT,
		MODE_REG_IND,
		MODE_DISP16,
		MODE_DISP24,
		MODE_POSTINC,
		MODE_PREDEC,
		MODE_ABS8,
		MODE_ABS16,
		MODE_ABS24,
		MODE_IMM,
		MODE_PCREL8,
		MODE_PCREL16,
		MODE_MEM_IND
	} ceau_mode_e;

	typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} ceau_size_e;
	typedef enum logic [2:0] {CL_ARITH, CL_XFER, CL_BIT, CL_BRANCH, CL_JUMP, CL_TRAP} ceau_class_e;
	typedef enum logic [2:0] {
		BOP_NONE, BOP_SET, BOP_CLR, BOP_INV, BOP_STORE, BOP_STORE_INV
	} ceau_bitop_e;
	typedef enum logic [1:0] {PART_LONG, PART_HALF, PART_BYTE} ceau_part_e;

	typedef struct packed {
		ceau_mode_e  mode;
		ceau_size_e  size;
		ceau_class_e iclass;
		ceau_bitop_e bitop;
		logic [1:0]  ext_words;
		logic        bit_from_reg;
		logic [2:0]  bit_reg;
		logic        carry;
		logic [23:0] pc_next;
		logic [31:0] areg;
	} ceau_req_s;

	typedef struct packed {
		logic [23:0] ea;
		logic [3:0]  opcode;
		logic [3:0]  opcode2;
		logic [2:0]  reg_addr;
		logic [3:0]  reg_data;
		ceau_part_e  reg_part;
		logic [31:0] imm;
		logic [1:0]  trap_vec;
		logic        wb_valid;
		logic [31:0] wb_value;
		logic        target_valid;
		logic [23:0] target;
		logic [7:0]  bit_byte;
		logic        illegal;
	} ceau_res_s;

	localparam int OPC_MSB = 15;
	localparam int OPC_LSB = 12;
	localparam int OP2_MSB = 11;
	localparam int OP2_LSB = 8;
	localparam int RA_MSB = 6;
	localparam int RA_LSB = 4;
	localparam int RD_MSB = 3;
	localparam int RD_LSB = 0;
	localparam int TRAP_MSB = 5;
	localparam int TRAP_LSB = 4;
	localparam logic [15:0] ABS8_UPPER = 16'hFFFF;
	localparam logic [15:0] MEMIND_UPPER = 16'h0000;
	localparam logic [7:0]  EXT24_TOP = 8'h00;
	localparam logic [7:0]  WO_READ = 8'hFF;
	localparam logic [23:0] MASK_1MB = 24'h0F_FFFF;
	localparam logic [23:0] MASK_16MB = 24'hFF_FFFF;
	localparam logic [31:0] STEP_BYTE = 32'h0000_0001;
	localparam logic [31:0] STEP_WORD = 32'h0000_0002;
	localparam logic [31:0] STEP_LONG = 32'h0000_0004;
	localparam ceau_res_s   RES_RESET = '0;

endpackage

/* hdl/ceau_top.sv */
// Purpose: Field extraction and effective address generation
// Assumes: Decoder supplies mode, size and class with the first word
// Notes:   Memory bus is same-clock logic; mode pin is asynchronous
`timescale 1ns/1ps

module ceau_top #(
	parameter logic [23:0] DDR_ADDR = 24'hFF_FFC0
) (
	input  wire logic               clk,
	input  wire logic               srst,
	input  wire logic               mode_1mb_pin,
	input  wire logic               start,
	input  ceau_pkg::ceau_req_s     req,
	input  wire logic               word_valid,
	input  wire logic [15:0]        word_data,
	output logic                    word_ready,
	input  wire logic               mem_ack,
	input  wire logic [31:0]        mem_rdata,
	output logic                    mem_req,
	output logic                    mem_we,
	output ceau_pkg::ceau_size_e    mem_size,
	output logic [23:0]             mem_addr,
	output logic [7:0]              mem_wdata,
	output logic                    done,
	output ceau_pkg::ceau_res_s     res
);

	typedef enum logic [2:0] {S_IDLE, S_FETCH, S_CALC, S_RD, S_WR, S_JRD} ceau_state_e;

	ceau_state_e         state_reg;
	ceau_state_e         state_next;
	ceau_pkg::ceau_req_s req_reg;
	logic [15:0]         word_reg;
	logic [31:0]         ext_reg;
	logic [1:0]          ext_cnt_reg;
	logic                sync1_reg;
	logic                sync2_reg;
	logic                sync3_reg;
	logic                mode_1mb_reg;
	logic [23:0]         addr_raw;
	logic [31:0]         wb_val;
	logic                wb_en;
	logic                is_mem;

	// Mode pin is a strap from outside; filtered so a glitch cannot flip the mask
	always_ff @(posedge clk) begin
		sync1_reg <= mode_1mb_pin;
		sync2_reg <= sync1_reg;
		sync3_reg <= sync2_reg;
		if (srst) begin
			mode_1mb_reg <= 1'b0;
		end else if (sync2_reg == sync3_reg) begin
			mode_1mb_reg <= sync3_reg;
		end
	end

	wire logic [23:0] addr_mask = mode_1mb_reg ? ceau_pkg::MASK_1MB : ceau_pkg::MASK_16MB;

	wire ceau_pkg::ceau_mode_e m = req_reg.mode;
	wire logic legal_arith  = (m == ceau_pkg::MODE_REG_DIRECT) || (m == ceau_pkg::MODE_IMM);
	wire logic legal_xfer   = !((m == ceau_pkg::MODE_PCREL8) || (m == ceau_pkg::MODE_PCREL16)
		|| (m == ceau_pkg::MODE_MEM_IND));
	wire logic legal_bit    = (m == ceau_pkg::MODE_REG_DIRECT) || (m == ceau_pkg::MODE_REG_IND)
		|| (m == ceau_pkg::MODE_ABS8);
	wire logic legal_branch = (m == ceau_pkg::MODE_PCREL8) || (m == ceau_pkg::MODE_PCREL16);
	wire logic legal_jump   = (m == ceau_pkg::MODE_REG_IND) || (m == ceau_pkg::MODE_ABS24)
		|| (m == ceau_pkg::MODE_MEM_IND);
	wire logic legal_trap   = (m == ceau_pkg::MODE_IMM);
	wire logic legal =
		(req_reg.iclass == ceau_pkg::CL_ARITH)  ? legal_arith  :
		(req_reg.iclass == ceau_pkg::CL_XFER)   ? legal_xfer   :
		(req_reg.iclass == ceau_pkg::CL_BIT)    ? legal_bit    :
		(req_reg.iclass == ceau_pkg::CL_BRANCH) ? legal_branch :
		(req_reg.iclass == ceau_pkg::CL_JUMP)   ? legal_jump   : legal_trap;

	wire logic [31:0] step = (req_reg.size == ceau_pkg::SZ_BYTE) ? ceau_pkg::STEP_BYTE :
		(req_reg.size == ceau_pkg::SZ_WORD) ? ceau_pkg::STEP_WORD : ceau_pkg::STEP_LONG;
	wire logic [31:0] disp16_sx = {{16{ext_reg[15]}}, ext_reg[15:0]};
	wire logic [31:0] disp24_zx = {ceau_pkg::EXT24_TOP, ext_reg[23:0]};
	wire logic [31:0] inc_val   = req_reg.areg + step;
	wire logic [31:0] dec_val   = req_reg.areg - step;
	wire logic [31:0] d16_sum   = req_reg.areg + disp16_sx;
	wire logic [31:0] d24_sum   = req_reg.areg + disp24_zx;
	wire logic [23:0] pc_d8     = req_reg.pc_next + {{16{word_reg[7]}}, word_reg[7:0]};
	wire logic [23:0] pc_d16    = req_reg.pc_next + {{8{ext_reg[15]}}, ext_reg[15:0]};

	always_comb begin
		addr_raw = 24'h00_0000;
		wb_val   = req_reg.areg;
		wb_en    = 1'b0;
		is_mem   = 1'b1;
		case (m)
			ceau_pkg::MODE_REG_IND: addr_raw = req_reg.areg[23:0];
			ceau_pkg::MODE_DISP16: addr_raw = d16_sum[23:0];
			ceau_pkg::MODE_DISP24: addr_raw = d24_sum[23:0];
			ceau_pkg::MODE_POSTINC: begin
				addr_raw = req_reg.areg[23:0];
				wb_val   = inc_val;
				wb_en    = 1'b1;
			end
			ceau_pkg::MODE_PREDEC: begin
				addr_raw = dec_val[23:0];
				wb_val   = dec_val;
				wb_en    = 1'b1;
			end
			ceau_pkg::MODE_ABS8: addr_raw = {ceau_pkg::ABS8_UPPER, word_reg[7:0]};
			ceau_pkg::MODE_ABS16: addr_raw = {{8{ext_reg[15]}}, ext_reg[15:0]};
			ceau_pkg::MODE_ABS24: addr_raw = ext_reg[23:0];
			ceau_pkg::MODE_PCREL8: addr_raw = pc_d8;
			ceau_pkg::MODE_PCREL16: addr_raw = pc_d16;
			ceau_pkg::MODE_MEM_IND: addr_raw = {ceau_pkg::MEMIND_UPPER, word_reg[7:0]};
			default: is_mem = 1'b0;
		endcase
	end

	// Branch and jump targets are always even, as are word and long operands
	wire logic need_even = (req_reg.size != ceau_pkg::SZ_BYTE) || (req_reg.iclass == ceau_pkg::CL_BRANCH)
		|| (req_reg.iclass == ceau_pkg::CL_JUMP) || (m == ceau_pkg::MODE_MEM_IND);
	wire logic [23:0] ea_calc = {addr_raw[23:1], addr_raw[0] & !need_even} & addr_mask;

	wire logic [31:0] imm_val = (req_reg.size == ceau_pkg::SZ_BYTE) ? {24'h00_0000, ext_reg[7:0]} :
		(req_reg.size == ceau_pkg::SZ_WORD) ? {16'h0000, ext_reg[15:0]} : ext_reg;

	localparam int RA_MSB_W = ceau_pkg::RA_MSB;
	localparam int RA_LSB_W = ceau_pkg::RA_LSB;
	wire logic [2:0] bit_num = req_reg.bit_from_reg ? req_reg.bit_reg : word_reg[RA_MSB_W:RA_LSB_W];
	wire logic [7:0] bit_mask = 8'h01 << bit_num;

	// Write-only register returns ones, so a modify there sets every other bit
	wire logic [7:0] rd_byte = (mem_addr == DDR_ADDR) ? ceau_pkg::WO_READ : mem_rdata[7:0];
	wire logic [7:0] src_byte = (state_reg == S_RD) ? rd_byte : req_reg.areg[7:0];
	wire logic [7:0] mod_byte =
		(req_reg.bitop == ceau_pkg::BOP_SET)       ? (src_byte | bit_mask) :
		(req_reg.bitop == ceau_pkg::BOP_CLR)       ? (src_byte & ~bit_mask) :
		(req_reg.bitop == ceau_pkg::BOP_INV)       ? (src_byte ^ bit_mask) :
		(req_reg.bitop == ceau_pkg::BOP_STORE)     ? (req_reg.carry ? (src_byte | bit_mask) : (src_byte & ~bit_mask)) :
		(req_reg.bitop == ceau_pkg::BOP_STORE_INV) ? (req_reg.carry ? (src_byte & ~bit_mask) : (src_byte | bit_mask)) :
		src_byte;

	wire logic rmw    = legal && is_mem && (req_reg.iclass == ceau_pkg::CL_BIT) && (req_reg.bitop != ceau_pkg::BOP_NONE);
	wire logic go_jrd = legal && (m == ceau_pkg::MODE_MEM_IND);
	wire logic [23:0] jtarget = {mem_rdata[23:1], 1'b0} & addr_mask;
	wire logic last_word = (ext_cnt_reg == 2'd1);
	wire logic take_word = word_ready && word_valid;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			S_IDLE: if (start) state_next = (req.ext_words == 2'd0) ? S_CALC : S_FETCH;
			S_FETCH: if (take_word && last_word) state_next = S_CALC;
			S_CALC: state_next = rmw ? S_RD : (go_jrd ? S_JRD : S_IDLE);
			S_RD: if (mem_ack) state_next = S_WR;
			S_WR: if (mem_ack) state_next = S_IDLE;
			S_JRD: if (mem_ack) state_next = S_IDLE;
			default: state_next = S_IDLE;
		endcase
	end

	wire logic [31:0] ext_next = {ext_reg[15:0], word_data};
	wire logic calc_done = (state_reg == S_CALC) && !rmw && !go_jrd;
	wire logic finish = calc_done || ((state_reg == S_WR || state_reg == S_JRD) && mem_ack);

	always_ff @(posedge clk) begin
		if (srst) begin
			state_reg   <= S_IDLE;
			req_reg     <= '0;
			word_reg    <= 16'h0000;
			ext_reg     <= 32'h0000_0000;
			ext_cnt_reg <= 2'd0;
		end else begin
			state_reg <= state_next;
			if (state_reg == S_IDLE && start) begin
				req_reg     <= req;
				word_reg    <= word_data;
				ext_reg     <= 32'h0000_0000;
				ext_cnt_reg <= req.ext_words;
			end else if (state_reg == S_FETCH && take_word) begin
				ext_reg     <= ext_next;
				ext_cnt_reg <= ext_cnt_reg - 2'd1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			word_ready <= 1'b0;
			done       <= 1'b0;
		end else begin
			word_ready <= (state_next == S_FETCH) && !(state_reg == S_FETCH && take_word && last_word);
			done       <= finish;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			mem_req   <= 1'b0;
			mem_we    <= 1'b0;
			mem_size  <= ceau_pkg::SZ_BYTE;
			mem_addr  <= 24'h00_0000;
			mem_wdata <= 8'h00;
		end else if (state_reg == S_CALC && (rmw || go_jrd)) begin
			mem_req  <= 1'b1;
			mem_we   <= 1'b0;
			mem_size <= rmw ? ceau_pkg::SZ_BYTE : ceau_pkg::SZ_LONG;
			mem_addr <= ea_calc;
		end else if (state_reg == S_RD && mem_ack) begin
			mem_we    <= 1'b1;
			mem_wdata <= mod_byte;
		end else if (mem_ack) begin
			mem_req <= 1'b0;
			mem_we  <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			res <= ceau_pkg::RES_RESET;
		end else if (state_reg == S_CALC) begin
			res.ea       <= ea_calc;
			res.opcode   <= word_reg[ceau_pkg::OPC_MSB:ceau_pkg::OPC_LSB];
			res.opcode2  <= word_reg[ceau_pkg::OP2_MSB:ceau_pkg::OP2_LSB];
			res.reg_addr <= word_reg[ceau_pkg::RA_MSB:ceau_pkg::RA_LSB];
			res.reg_data <= word_reg[ceau_pkg::RD_MSB:ceau_pkg::RD_LSB];
			res.reg_part <= (req_reg.size == ceau_pkg::SZ_LONG) ? ceau_pkg::PART_LONG :
				(req_reg.size == ceau_pkg::SZ_WORD) ? ceau_pkg::PART_HALF : ceau_pkg::PART_BYTE;
			res.imm      <= imm_val;
			res.trap_vec <= word_reg[ceau_pkg::TRAP_MSB:ceau_pkg::TRAP_LSB];
			res.wb_valid <= wb_en && legal;
			res.wb_value <= wb_val;
			res.target_valid <= legal && (req_reg.iclass == ceau_pkg::CL_BRANCH || req_reg.iclass == ceau_pkg::CL_JUMP)
				&& !go_jrd;
			res.target   <= ea_calc;
			res.bit_byte <= mod_byte;
			res.illegal  <= !legal;
		end else if (state_reg == S_RD && mem_ack) begin
			res.bit_byte <= mod_byte;
		end else if (state_reg == S_JRD && mem_ack) begin
			res.target_valid <= 1'b1;
			res.target       <= jtarget;
		end
	end

	sequence seq_rmw_read;
		mem_req && !mem_we && mem_ack && (mem_size == ceau_pkg::SZ_BYTE);
	endsequence
	sequence seq_rmw_write;
		mem_req && mem_we && (mem_size == ceau_pkg::SZ_BYTE);
	endsequence

	AST_RMW_SAME_ADDR: assert property (@(posedge clk) disable iff (srst)
		seq_rmw_read |=> seq_rmw_write and (mem_addr == $past(mem_addr)))
		else $error("Bit write-back not at read address");

	AST_WO_ONES: assert property (@(posedge clk) disable iff (srst)
		(mem_req && mem_we && mem_addr == DDR_ADDR) |-> ($countones(mem_wdata) >= 7))
		else $error("Direction register write-back lost ones");

	AST_EVEN_ADDR: assert property (@(posedge clk) disable iff (srst)
		(done && res.target_valid) |-> (res.target[0] == 1'b0))
		else $error("Branch target is odd");

	AST_TRUNC_20: assert property (@(posedge clk) disable iff (srst)
		(done && mode_1mb_reg && $past(mode_1mb_reg, 2)) |-> (res.ea[23:20] == 4'h0))
		else $error("Address not truncated in 1-Mbyte mode");

	AST_MEMIND_LOW: assert property (@(posedge clk) disable iff (srst)
		(mem_req && mem_size == ceau_pkg::SZ_LONG) |-> (mem_addr[23:8] == 16'h0000) && (mem_addr[0] == 1'b0))
		else $error("Memory indirect read outside first 256 bytes");

	AST_POSTINC_STEP: assert property (@(posedge clk) disable iff (srst)
		(state_reg == S_CALC && m == ceau_pkg::MODE_POSTINC && legal)
		|=> res.wb_valid && (res.wb_value - req_reg.areg == step)
		&& (res.ea == (req_reg.areg[23:0] & addr_mask & ~{23'h0, need_even})))
		else $error("Post-increment step or address wrong");

	AST_PREDEC_USE: assert property (@(posedge clk) disable iff (srst)
		(state_reg == S_CALC && m == ceau_pkg::MODE_PREDEC && legal)
		|=> (req_reg.areg - res.wb_value == step) && (res.ea == (res.wb_value[23:0] & addr_mask & ~{23'h0, need_even})))
		else $error("Pre-decrement address wrong");

	AST_ABS8_TOP: assert property (@(posedge clk) disable iff (srst)
		(state_reg == S_CALC && m == ceau_pkg::MODE_ABS8 && !mode_1mb_reg) |=> (res.ea[23:8] == 16'hFFFF))
		else $error("Short absolute not in top page");

	AST_ARITH_MODES: assert property (@(posedge clk) disable iff (srst)
		(state_reg == S_CALC && req_reg.iclass == ceau_pkg::CL_ARITH && !legal_arith) |=> res.illegal && done)
		else $error("Arithmetic accepted a memory mode");

	AST_FETCH_DONE: assert property (@(posedge clk) disable iff (srst)
		(state_reg == S_IDLE && start && req.ext_words == 2'd0) |=> (state_reg == S_CALC) ##1 (state_reg != S_FETCH))
		else $error("Single word instruction waited for extension");

endmodule

/* verif/ceau_mem_model.sv */
// Purpose: Memory bus partner of the effective address unit
// Assumes: Same clock as the unit; acknowledge is a one-cycle pulse
// Notes:   Read data outside an acknowledge is a moving pattern, never the last value
`timescale 1ns/1ps

module ceau_mem_model (
	input  wire logic           clk,
	input  wire logic           srst,
	input  wire logic [3:0]     lat,
	input  wire logic           mem_req,
	input  wire logic           mem_we,
	input  ceau_pkg::ceau_size_e mem_size,
	input  wire logic [23:0]    mem_addr,
	input  wire logic [7:0]     mem_wdata,
	output logic                mem_ack,
	output logic [31:0]         mem_rdata
);
	logic [7:0]           mem [int];
	logic [31:0]          rd_q;
	logic [7:0]           junk;
	logic [3:0]           cnt;
	int                   rd_count;
	int                   wr_count;
	logic [23:0]          last_raddr;
	logic [23:0]          last_waddr;
	logic [7:0]           last_wdata;
	ceau_pkg::ceau_size_e last_rsize;

	function automatic logic [7:0] peek(logic [23:0] a);
		return mem.exists(int'(a)) ? mem[int'(a)] : 8'h3C;
	endfunction

	initial begin
		mem_ack = 1'b0;
		junk = 8'h00;
		cnt = 4'h0;
		rd_count = 0;
		wr_count = 0;
	end

	// Stale data would let a late sample pass by luck
	assign mem_rdata = mem_ack ? rd_q : {junk, ~junk, junk, ~junk};

	always @(posedge clk) begin
		junk <= junk + 8'h3B;
		mem_ack <= 1'b0;
		if (srst) begin
			cnt <= 4'h0;
		end else if (mem_req && !mem_ack) begin
			if (cnt >= lat) begin
				mem_ack <= 1'b1;
				cnt <= 4'h0;
				if (mem_we) begin
					mem[int'(mem_addr)] = mem_wdata;
					last_waddr <= mem_addr;
					last_wdata <= mem_wdata;
					wr_count++;
				end else begin
					// Big-endian longword; first byte is real memory so dropping it is tested
					rd_q <= (mem_size == ceau_pkg::SZ_LONG) ?
						{peek(mem_addr), peek(mem_addr + 24'h1), peek(mem_addr + 24'h2), peek(mem_addr + 24'h3)} :
						{junk, junk, junk, peek(mem_addr)};
					last_raddr <= mem_addr;
					last_rsize <= mem_size;
					rd_count++;
				end
			end else begin
				cnt <= cnt + 4'h1;
			end
		end
	end
endmodule

/* verif/cpu_effective_address_unit_tb.sv */
// Purpose: Self-checking bench of the effective address unit
// Assumes: Inputs change on the falling edge; results read while done stands
// Notes:   mk() copies areg into pc_next, so one argument serves both
`timescale 1ns/1ps

`define CHK(a, b) begin checks++; if ((a) !== (b)) begin mismatches++; \
	$display("FAIL t=%0t got=%h exp=%h", $time, (a), (b)); end end

module cpu_effective_address_unit_tb;
	logic                 clk;
	logic                 srst;
	logic                 mode_1mb_pin;
	logic                 start;
	ceau_pkg::ceau_req_s  req;
	logic                 word_valid;
	logic [15:0]          word_data;
	logic                 word_ready;
	logic                 mem_ack;
	logic [31:0]          mem_rdata;
	logic                 mem_req;
	logic                 mem_we;
	ceau_pkg::ceau_size_e mem_size;
	logic [23:0]          mem_addr;
	logic [7:0]           mem_wdata;
	logic                 done;
	ceau_pkg::ceau_res_s  res;
	logic [3:0]           mem_lat;
	int                   mismatches;
	int                   checks;

	ceau_top #(.DDR_ADDR(24'hFF_FFC0)) i_dut (.clk(clk), .srst(srst), .mode_1mb_pin(mode_1mb_pin),
		.start(start), .req(req), .word_valid(word_valid), .word_data(word_data), .word_ready(word_ready),
		.mem_ack(mem_ack), .mem_rdata(mem_rdata), .mem_req(mem_req), .mem_we(mem_we), .mem_size(mem_size),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .done(done), .res(res));

	ceau_mem_model i_mem (.clk(clk), .srst(srst), .lat(mem_lat), .mem_req(mem_req), .mem_we(mem_we),
		.mem_size(mem_size), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
		.mem_rdata(mem_rdata));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	task automatic wrap_up();
		if (mismatches == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	function automatic ceau_pkg::ceau_req_s mk(ceau_pkg::ceau_mode_e m, ceau_pkg::ceau_size_e s,
		ceau_pkg::ceau_class_e c, logic [31:0] a, logic [1:0] n);
		ceau_pkg::ceau_req_s r;
		r = '0;
		r.mode = m;
		r.size = s;
		r.iclass = c;
		r.areg = a;
		r.pc_next = a[23:0];
		r.ext_words = n;
		return r;
	endfunction

	// Extension words go first-high; the wait is bounded so a stuck handshake still ends
	task automatic run(input ceau_pkg::ceau_req_s r, input logic [15:0] w, input logic [31:0] ext);
		int k;
		int n;
		@(negedge clk);
		req = r;
		word_data = w;
		start = 1'b1;
		@(negedge clk);
		start = 1'b0;
		for (k = int'(r.ext_words); k > 0; k--) begin
			word_valid = 1'b1;
			word_data = (k == 2) ? ext[31:16] : ext[15:0];
			n = 0;
			// Ready is judged settled at the falling edge; the next rising edge takes the word
			while (word_ready !== 1'b1 && n < 20) begin
				@(negedge clk);
				n++;
			end
			@(negedge clk);
		end
		word_valid = 1'b0;
		n = 0;
		while (done !== 1'b1 && n < 40) begin
			@(negedge clk);
			n++;
		end
		`CHK(done, 1'b1)
	endtask

	task automatic ea(ceau_pkg::ceau_mode_e m, ceau_pkg::ceau_size_e s, logic [31:0] a, logic [15:0] w,
		logic [1:0] n, logic [31:0] ext, logic [23:0] exp);
		run(mk(m, s, ceau_pkg::CL_XFER, a, n), w, ext);
		`CHK(res.ea, exp)
	endtask

	task automatic t_reset();
		`CHK(done, 1'b0)
		`CHK(mem_req, 1'b0)
		`CHK(word_ready, 1'b0)
		`CHK(res, ceau_pkg::RES_RESET)
	endtask

	task automatic t_fields();
		int s;
		for (s = 0; s < 3; s++) begin
			run(mk(ceau_pkg::MODE_REG_DIRECT, ceau_pkg::ceau_size_e'(s), ceau_pkg::CL_ARITH, 32'h0, 2'd0),
				16'h9B5C, 32'h0);
			`CHK(res.opcode, 4'h9)
			`CHK(res.opcode2, 4'hB)
			`CHK(res.reg_addr, 3'h5)
			`CHK(res.reg_data, 4'hC)
			`CHK(res.reg_part, (s == 0) ? ceau_pkg::PART_BYTE : (s == 1) ? ceau_pkg::PART_HALF : ceau_pkg::PART_LONG)
			`CHK(res.illegal, 1'b0)
		end
		run(mk(ceau_pkg::MODE_IMM, ceau_pkg::SZ_BYTE, ceau_pkg::CL_TRAP, 32'h0, 2'd0), 16'h5020, 32'h0);
		`CHK(res.trap_vec, 2'h2)
	endtask

	task automatic t_imm();
		run(mk(ceau_pkg::MODE_IMM, ceau_pkg::SZ_BYTE, ceau_pkg::CL_ARITH, 32'h0, 2'd1), 16'h1000, 32'h1234);
		`CHK(res.imm, 32'h0000_0034)
		run(mk(ceau_pkg::MODE_IMM, ceau_pkg::SZ_WORD, ceau_pkg::CL_ARITH, 32'h0, 2'd1), 16'h1000, 32'hBEEF);
		`CHK(res.imm, 32'h0000_BEEF)
		run(mk(ceau_pkg::MODE_IMM, ceau_pkg::SZ_LONG, ceau_pkg::CL_ARITH, 32'h0, 2'd2), 16'h1000, 32'h1234_5678);
		`CHK(res.imm, 32'h1234_5678)
	endtask

	task automatic t_addr();
		ea(ceau_pkg::MODE_REG_IND, ceau_pkg::SZ_BYTE, 32'h12AB_CDEF, 16'h0, 2'd0, 32'h0, 24'hAB_CDEF);
		ea(ceau_pkg::MODE_REG_IND, ceau_pkg::SZ_WORD, 32'h0000_1235, 16'h0, 2'd0, 32'h0, 24'h00_1234);
		ea(ceau_pkg::MODE_DISP16, ceau_pkg::SZ_BYTE, 32'h0010_0000, 16'h0, 2'd1, 32'hFFFE, 24'h0F_FFFE);
		ea(ceau_pkg::MODE_DISP24, ceau_pkg::SZ_BYTE, 32'h0010_0000, 16'h0, 2'd2, 32'h7F01_0203, 24'h11_0203);
		ea(ceau_pkg::MODE_ABS8, ceau_pkg::SZ_BYTE, 32'h0, 16'h0035, 2'd0, 32'h0, 24'hFF_FF35);
		ea(ceau_pkg::MODE_ABS16, ceau_pkg::SZ_BYTE, 32'h0, 16'h0, 2'd1, 32'h8001, 24'hFF_8001);
		ea(ceau_pkg::MODE_ABS16, ceau_pkg::SZ_WORD, 32'h0, 16'h0, 2'd1, 32'h8001, 24'hFF_8000);
		ea(ceau_pkg::MODE_ABS16, ceau_pkg::SZ_BYTE, 32'h0, 16'h0, 2'd1, 32'h7FFF, 24'h00_7FFF);
		ea(ceau_pkg::MODE_ABS24, ceau_pkg::SZ_BYTE, 32'h0, 16'h0, 2'd2, 32'h00AB_CDEF, 24'hAB_CDEF);
		mode_1mb_pin = 1'b1;
		repeat (6) @(negedge clk);
		ea(ceau_pkg::MODE_ABS24, ceau_pkg::SZ_BYTE, 32'h0, 16'h0, 2'd2, 32'h00AB_CDEF, 24'h0B_CDEF);
		ea(ceau_pkg::MODE_ABS8, ceau_pkg::SZ_BYTE, 32'h0, 16'h0035, 2'd0, 32'h0, 24'h0F_FF35);
		ea(ceau_pkg::MODE_REG_IND, ceau_pkg::SZ_BYTE, 32'h12AB_CDEF, 16'h0, 2'd0, 32'h0, 24'h0B_CDEF);
		mode_1mb_pin = 1'b0;
		repeat (6) @(negedge clk);
	endtask

	task automatic t_incdec();
		int s;
		for (s = 0; s < 3; s++) begin
			ea(ceau_pkg::MODE_POSTINC, ceau_pkg::ceau_size_e'(s), 32'h8000_1000, 16'h0, 2'd0, 32'h0, 24'h00_1000);
			`CHK(res.wb_valid, 1'b1)
			`CHK(res.wb_value, 32'h8000_1000 + (32'h1 << s))
			ea(ceau_pkg::MODE_PREDEC, ceau_pkg::ceau_size_e'(s), 32'h8000_1000, 16'h0, 2'd0, 32'h0, 24'h00_1000 - (24'h1 << s));
			`CHK(res.wb_value, 32'h8000_1000 - (32'h1 << s))
		end
	endtask

	task automatic t_branch();
		int rc;
		run(mk(ceau_pkg::MODE_PCREL8, ceau_pkg::SZ_BYTE, ceau_pkg::CL_BRANCH, 32'h1000, 2'd0), 16'h4080, 32'h0);
		`CHK(res.target_valid, 1'b1)
		`CHK(res.target, 24'h00_0F80)
		run(mk(ceau_pkg::MODE_PCREL16, ceau_pkg::SZ_BYTE, ceau_pkg::CL_BRANCH, 32'h1000, 2'd1), 16'h4000, 32'h7FFF);
		`CHK(res.target, 24'h00_8FFE)
		// Slow memory makes the unit hold its request across several cycles
		mem_lat = 4'd3;
		i_mem.mem[32'h40] = 8'h99;
		i_mem.mem[32'h41] = 8'h12;
		i_mem.mem[32'h42] = 8'h34;
		i_mem.mem[32'h43] = 8'h57;
		rc = i_mem.rd_count;
		run(mk(ceau_pkg::MODE_MEM_IND, ceau_pkg::SZ_LONG, ceau_pkg::CL_JUMP, 32'h0, 2'd0), 16'h2041, 32'h0);
		`CHK(i_mem.rd_count, rc + 1)
		`CHK(i_mem.last_raddr, 24'h00_0040)
		`CHK(i_mem.last_rsize, ceau_pkg::SZ_LONG)
		`CHK(res.target, 24'h12_3456)
		mem_lat = 4'd0;
	endtask

	task automatic bit_op(ceau_pkg::ceau_mode_e m, ceau_pkg::ceau_bitop_e op, logic [31:0] a, logic [15:0] w,
		logic [2:0] b, logic [23:0] ad, logic [7:0] init, logic [7:0] exp, int nacc);
		ceau_pkg::ceau_req_s r;
		int rc;
		int wc;
		r = mk(m, ceau_pkg::SZ_BYTE, ceau_pkg::CL_BIT, a, 2'd0);
		r.bitop = op;
		r.bit_reg = b;
		r.bit_from_reg = (m == ceau_pkg::MODE_REG_IND);
		r.carry = (op != ceau_pkg::BOP_STORE_INV);
		i_mem.mem[int'(ad)] = init;
		rc = i_mem.rd_count;
		wc = i_mem.wr_count;
		run(r, w, 32'h0);
		`CHK(i_mem.rd_count, rc + nacc)
		`CHK(i_mem.wr_count, wc + nacc)
		`CHK(res.bit_byte, exp)
		if (nacc > 0) begin
			`CHK(i_mem.last_raddr, ad)
			`CHK(i_mem.last_waddr, ad)
			`CHK(i_mem.last_wdata, exp)
		end
	endtask

	task automatic t_bits();
		bit_op(ceau_pkg::MODE_ABS8, ceau_pkg::BOP_SET, 32'h0, 16'h7030, 3'd3, 24'hFF_FF30, 8'h00, 8'h08, 1);
		mem_lat = 4'd2;
		bit_op(ceau_pkg::MODE_ABS8, ceau_pkg::BOP_CLR, 32'h0, 16'h7030, 3'd3, 24'hFF_FF30, 8'hFF, 8'hF7, 1);
		bit_op(ceau_pkg::MODE_ABS8, ceau_pkg::BOP_INV, 32'h0, 16'h7030, 3'd3, 24'hFF_FF30, 8'h0F, 8'h07, 1);
		mem_lat = 4'd0;
		bit_op(ceau_pkg::MODE_ABS8, ceau_pkg::BOP_STORE, 32'h0, 16'h7030, 3'd3, 24'hFF_FF30, 8'h00, 8'h08, 1);
		bit_op(ceau_pkg::MODE_ABS8, ceau_pkg::BOP_STORE_INV, 32'h0, 16'h7030, 3'd3, 24'hFF_FF30, 8'h00, 8'h08, 1);
		bit_op(ceau_pkg::MODE_ABS8, ceau_pkg::BOP_CLR, 32'h0, 16'h70C0, 3'd4, 24'hFF_FFC0, 8'h3F, 8'hEF, 1);
		bit_op(ceau_pkg::MODE_REG_IND, ceau_pkg::BOP_SET, 32'h00FF_FF30, 16'h7000, 3'd3, 24'hFF_FF30, 8'h00, 8'h08, 1);
		bit_op(ceau_pkg::MODE_REG_DIRECT, ceau_pkg::BOP_INV, 32'h0000_000F, 16'h7030, 3'd3, 24'h0, 8'h00, 8'h07, 0);
	endtask

	task automatic bad(ceau_pkg::ceau_mode_e m, ceau_pkg::ceau_class_e c, logic [1:0] n);
		int acc;
		ceau_pkg::ceau_req_s r;
		acc = i_mem.rd_count + i_mem.wr_count;
		// A bit operation is asked for, so a wrongly accepted bit-class mode shows up as bus traffic
		r = mk(m, ceau_pkg::SZ_BYTE, c, 32'h0, n);
		r.bitop = ceau_pkg::BOP_SET;
		run(r, 16'h0030, 32'h1234);
		`CHK(res.illegal, 1'b1)
		`CHK(i_mem.rd_count + i_mem.wr_count, acc)
	endtask

	task automatic t_illegal();
		bad(ceau_pkg::MODE_REG_IND, ceau_pkg::CL_ARITH, 2'd0);
		bad(ceau_pkg::MODE_PCREL8, ceau_pkg::CL_XFER, 2'd0);
		bad(ceau_pkg::MODE_MEM_IND, ceau_pkg::CL_XFER, 2'd0);
		bad(ceau_pkg::MODE_DISP16, ceau_pkg::CL_BIT, 2'd1);
		bad(ceau_pkg::MODE_ABS16, ceau_pkg::CL_BIT, 2'd1);
	endtask

	initial begin
		mismatches = 0;
		checks = 0;
		srst = 1'b1;
		mode_1mb_pin = 1'b0;
		start = 1'b0;
		req = '0;
		word_valid = 1'b0;
		word_data = 16'h0000;
		mem_lat = 4'd0;
		repeat (2) @(negedge clk);
		srst = 1'b0;
		t_reset();
		t_fields();
		t_imm();
		t_addr();
		t_incdec();
		t_branch();
		t_bits();
		t_illegal();
		wrap_up();
	end

	// About 40 operations of at most a few dozen cycles each
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		wrap_up();
	end
endmodule
